// File: clock_power_defines.svh
// offsets, field positions, reset values and timing counts for the clock and power controller
`ifndef CLOCK_POWER_DEFINES_SVH
`define CLOCK_POWER_DEFINES_SVH
`define SPEED_CONTROL_ADDR 8'h8f
`define PRESCALER_RELOAD_ADDR 8'h97
`define POWER_CONTROL_ADDR 8'h87
`define SOURCE_SELECT_ADDR 8'h85
`define SPEED_CONTROL_RESET 8'h00
`define PRESCALER_RELOAD_RESET 4'h8
`define SOURCE_SELECT_RESET 2'h3
`define DOUBLE_SPEED_BIT 0
`define IDLE_REQUEST_BIT 0
`define POWER_DOWN_REQUEST_BIT 1
`define USER_FLAG_ZERO_BIT 2
`define USER_FLAG_ONE_BIT 3
`define SOURCE_CRYSTAL 2'h3
`define SOURCE_PRECISE_RC 2'h2
`define SOURCE_LOW_POWER_RC 2'h1
`define RESET_HOLD_OSC_PERIODS 24
`endif

// File: clock_power_pkg.sv
// types shared by the clock and power controller
package clock_power_pkg;
  typedef enum logic [1:0] {
    mode_run,
    mode_idle,
    mode_quiet,
    mode_power_down
  } power_mode_t;
  typedef enum logic [1:0] {
    wake_none,
    wake_held,
    wake_done
  } wake_state_t;
endpackage

// File: prescale_divider.sv
// divide-by-(16-m) prescaler with reload at period boundary
`include "clock_power_defines.svh"
module prescale_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reload_i,
  output logic tick_o
);
  // ==========================================================
  // counter
  logic [3:0] count_ff;
  logic [3:0] nxt_count;
  logic tick_ff;
  logic nxt_tick;
  always_comb begin
    nxt_count = count_ff + 4'h1;
    nxt_tick = 1'b0;
    if (count_ff == 4'hf) begin
      // new reload only at the boundary so no period is ever truncated
      nxt_count = reload_i;
      nxt_tick = 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff <= `PRESCALER_RELOAD_RESET;
      tick_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end
  assign tick_o = tick_ff;
  // divide by one keeps the tick high every cycle, so only longer periods must drop it
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_ff && count_ff != 4'hf |=> !tick_ff) else $error("prescaler tick lasted more than one cycle");
endmodule // prescale_divider

// File: clock_prescale_power_modes.sv
// clock prescaler, source select and power mode controller
`include "clock_power_defines.svh"
module clock_prescale_power_modes (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic instr_end_i,
  input wire logic irq_pending_i,
  input wire logic quiet_request_i,
  input wire logic external_irq_zero_n_i,
  input wire logic external_irq_one_n_i,
  input wire logic irq_zero_enable_i,
  input wire logic irq_one_enable_i,
  input wire logic crystal_ready_i,
  input wire logic precise_rc_ready_i,
  input wire logic low_power_rc_ready_i,
  output logic [7:0] reg_rdata_o,
  output logic cpu_clock_enable_o,
  output logic periph_clock_enable_o,
  output logic adc_clock_enable_o,
  output logic oscillator_run_o,
  output logic [1:0] selected_osc_o,
  output logic port_hold_o,
  output logic strobes_high_o
);
  // ==========================================================
  // registers
  logic double_speed_ff;
  logic nxt_double_speed;
  logic [3:0] prescaler_reload_ff;
  logic [3:0] nxt_prescaler_reload;
  logic [1:0] source_select_bits_ff;
  logic [1:0] nxt_source_select_bits;
  logic [3:0] power_control_ff;
  logic [3:0] nxt_power_control;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic wr_speed;
  logic wr_reload;
  logic wr_source;
  logic wr_power;
  logic wake_now;
  logic div_tick;
  assign wr_speed = reg_write_i && (reg_addr_i == `SPEED_CONTROL_ADDR);
  assign wr_reload = reg_write_i && (reg_addr_i == `PRESCALER_RELOAD_ADDR);
  assign wr_source = reg_write_i && (reg_addr_i == `SOURCE_SELECT_ADDR);
  assign wr_power = reg_write_i && (reg_addr_i == `POWER_CONTROL_ADDR);
  // ==========================================================
  // external irq synchronisers
  logic [1:0] irq0_sync_ff;
  logic [1:0] irq1_sync_ff;
  logic [1:0] nxt_irq0_sync;
  logic [1:0] nxt_irq1_sync;
  always_comb begin
    nxt_irq0_sync = {irq0_sync_ff[0], external_irq_zero_n_i};
    nxt_irq1_sync = {irq1_sync_ff[0], external_irq_one_n_i};
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq0_sync_ff <= 2'h3;
      irq1_sync_ff <= 2'h3;
    end else begin
      irq0_sync_ff <= nxt_irq0_sync;
      irq1_sync_ff <= nxt_irq1_sync;
    end
  end
  logic irq0_low;
  logic irq1_low;
  // edge or level configuration is ignored: only the low level counts
  assign irq0_low = irq_zero_enable_i && !irq0_sync_ff[1];
  assign irq1_low = irq_one_enable_i && !irq1_sync_ff[1];
  // ==========================================================
  // register file
  always_comb begin
    nxt_double_speed = double_speed_ff;
    nxt_prescaler_reload = prescaler_reload_ff;
    nxt_source_select_bits = source_select_bits_ff;
    nxt_power_control = power_control_ff;
    if (wr_speed) begin
      nxt_double_speed = reg_wdata_i[`DOUBLE_SPEED_BIT];
    end
    if (wr_reload) begin
      nxt_prescaler_reload = reg_wdata_i[3:0];
    end
    // reserved code 00 is ignored; leaving any mode never touches this field
    if (wr_source && (reg_wdata_i[1:0] != 2'h0)) begin
      nxt_source_select_bits = reg_wdata_i[1:0];
    end
    if (wr_power) begin
      nxt_power_control = reg_wdata_i[3:0];
    end
    // hardware clear on interrupt wins; the cpu cannot write in the same cycle while halted
    if (wake_now) begin
      nxt_power_control[`IDLE_REQUEST_BIT] = 1'b0;
      nxt_power_control[`POWER_DOWN_REQUEST_BIT] = 1'b0;
    end
  end
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      `SPEED_CONTROL_ADDR: nxt_rdata = {7'h00, double_speed_ff};
      `PRESCALER_RELOAD_ADDR: nxt_rdata = {4'h0, prescaler_reload_ff};
      `SOURCE_SELECT_ADDR: nxt_rdata = {6'h00, source_select_bits_ff};
      `POWER_CONTROL_ADDR: nxt_rdata = {4'h0, power_control_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      double_speed_ff <= 1'(`SPEED_CONTROL_RESET);
      prescaler_reload_ff <= `PRESCALER_RELOAD_RESET;
      source_select_bits_ff <= `SOURCE_SELECT_RESET;
      power_control_ff <= 4'h0;
      rdata_ff <= 8'h00;
    end else begin
      double_speed_ff <= nxt_double_speed;
      prescaler_reload_ff <= nxt_prescaler_reload;
      source_select_bits_ff <= nxt_source_select_bits;
      power_control_ff <= nxt_power_control;
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_o = rdata_ff;
  // ==========================================================
  // source switch: change only when the new oscillator is ready
  logic [1:0] active_source_ff;
  logic [1:0] nxt_active_source;
  logic new_ready;
  always_comb begin
    case (source_select_bits_ff)
      `SOURCE_CRYSTAL: new_ready = crystal_ready_i;
      `SOURCE_PRECISE_RC: new_ready = precise_rc_ready_i;
      `SOURCE_LOW_POWER_RC: new_ready = low_power_rc_ready_i;
      default: new_ready = 1'b0;
    endcase
    nxt_active_source = active_source_ff;
    // swap lands only on a prescaler tick so both clocks are idle low
    if (new_ready && div_tick) begin
      nxt_active_source = source_select_bits_ff;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_source_ff <= `SOURCE_SELECT_RESET;
    end else begin
      active_source_ff <= nxt_active_source;
    end
  end
  // ==========================================================
  // prescaler
  prescale_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reload_i(prescaler_reload_ff),
    .tick_o(div_tick)
  );
  logic clock_step;
  assign clock_step = double_speed_ff ? 1'b1 : div_tick;
  // ==========================================================
  // power mode machine
  clock_power_pkg::power_mode_t mode_ff;
  clock_power_pkg::power_mode_t nxt_mode;
  clock_power_pkg::wake_state_t wake_ff;
  clock_power_pkg::wake_state_t nxt_wake;
  logic any_low;
  assign any_low = irq0_low || irq1_low;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_wake = wake_ff;
    wake_now = 1'b0;
    case (mode_ff)
      clock_power_pkg::mode_run: begin
        if (instr_end_i && power_control_ff[`POWER_DOWN_REQUEST_BIT]) begin
          nxt_mode = clock_power_pkg::mode_power_down;
        end else if (instr_end_i && power_control_ff[`IDLE_REQUEST_BIT]) begin
          nxt_mode = clock_power_pkg::mode_idle;
        end else if (instr_end_i && quiet_request_i) begin
          nxt_mode = clock_power_pkg::mode_quiet;
        end
      end
      clock_power_pkg::mode_idle: begin
        if (irq_pending_i) begin
          wake_now = 1'b1;
          nxt_mode = clock_power_pkg::mode_run;
        end
      end
      clock_power_pkg::mode_quiet: begin
        if (irq_pending_i) begin
          nxt_mode = clock_power_pkg::mode_run;
        end
      end
      clock_power_pkg::mode_power_down: begin
        case (wake_ff)
          clock_power_pkg::wake_none: begin
            if (any_low) begin
              nxt_wake = clock_power_pkg::wake_held;
            end
          end
          clock_power_pkg::wake_held: begin
            // any enabled line seen high ends the exit, whether it is the first one released or one never held low
            if ((irq_zero_enable_i && irq0_sync_ff[1]) || (irq_one_enable_i && irq1_sync_ff[1])) begin
              nxt_wake = clock_power_pkg::wake_none;
              wake_now = 1'b1;
              nxt_mode = clock_power_pkg::mode_run;
            end
          end
          default: nxt_wake = clock_power_pkg::wake_none;
        endcase
      end
      default: nxt_mode = clock_power_pkg::mode_run;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= clock_power_pkg::mode_run;
      wake_ff <= clock_power_pkg::wake_none;
    end else begin
      mode_ff <= nxt_mode;
      wake_ff <= nxt_wake;
    end
  end
  // ==========================================================
  // outputs
  logic cpu_en_ff;
  logic periph_en_ff;
  logic adc_en_ff;
  logic osc_run_ff;
  logic hold_ff;
  logic strobe_ff;
  logic [1:0] sel_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_en_ff <= 1'b0;
      periph_en_ff <= 1'b0;
      adc_en_ff <= 1'b0;
      osc_run_ff <= 1'b1;
      hold_ff <= 1'b0;
      strobe_ff <= 1'b0;
      sel_ff <= `SOURCE_SELECT_RESET;
    end else begin
      cpu_en_ff <= clock_step && (nxt_mode == clock_power_pkg::mode_run);
      periph_en_ff <= clock_step && ((nxt_mode == clock_power_pkg::mode_run)
                      || (nxt_mode == clock_power_pkg::mode_idle));
      adc_en_ff <= clock_step && (nxt_mode != clock_power_pkg::mode_power_down);
      // oscillator restarts as soon as a wake line is held low
      osc_run_ff <= (nxt_mode != clock_power_pkg::mode_power_down)
                    || (nxt_wake == clock_power_pkg::wake_held);
      hold_ff <= nxt_mode != clock_power_pkg::mode_run;
      strobe_ff <= nxt_mode == clock_power_pkg::mode_idle;
      sel_ff <= nxt_active_source;
    end
  end
  assign cpu_clock_enable_o = cpu_en_ff;
  assign periph_clock_enable_o = periph_en_ff;
  assign adc_clock_enable_o = adc_en_ff;
  assign oscillator_run_o = osc_run_ff;
  assign port_hold_o = hold_ff;
  assign strobes_high_o = strobe_ff;
  assign selected_osc_o = sel_ff;
  // ==========================================================
  // checks
  sequence s_pd_entry;
    mode_ff == clock_power_pkg::mode_run && instr_end_i && power_control_ff[`POWER_DOWN_REQUEST_BIT];
  endsequence
  a_pd_precedence: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pd_entry |=> mode_ff == clock_power_pkg::mode_power_down) else $error("power down not entered");
  a_pd_osc_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pd_entry |=> ##1 !oscillator_run_o || any_low) else $error("oscillator still running");
  a_idle_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ff == clock_power_pkg::mode_run && instr_end_i && power_control_ff == 4'h1
    |=> mode_ff == clock_power_pkg::mode_idle) else $error("idle not entered");
  a_idle_cpu_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ff == clock_power_pkg::mode_idle && $past(mode_ff) == clock_power_pkg::mode_idle
    |-> !cpu_clock_enable_o && strobes_high_o) else $error("cpu clock or strobes wrong in idle");
  a_idle_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_ff == clock_power_pkg::mode_idle && irq_pending_i
    |=> !power_control_ff[`IDLE_REQUEST_BIT] && mode_ff == clock_power_pkg::mode_run) else $error("idle exit");
  a_source_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_now && !wr_source |=> $stable(source_select_bits_ff)) else $error("source bits changed on wake");
  a_double_speed: assert property (@(posedge clk_i) disable iff (rst_i)
    double_speed_ff && mode_ff == clock_power_pkg::mode_run && nxt_mode == clock_power_pkg::mode_run
    |=> cpu_clock_enable_o) else $error("double speed not bypassing");
  a_pd_release: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_ff == clock_power_pkg::wake_held && mode_ff == clock_power_pkg::mode_power_down
    && irq_zero_enable_i && irq0_sync_ff[1] |=> mode_ff == clock_power_pkg::mode_run) else $error("no exit");
endmodule // clock_prescale_power_modes

// File: cpu_osc_model.sv
// behavioural model of the cpu core and oscillators around the clock and power controller
module cpu_osc_model #(
  parameter int CRYSTAL_DELAY = 12,
  parameter int RC_DELAY = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic cpu_clock_enable_i,
  input wire logic oscillator_run_i,
  output logic instr_end_o,
  output logic crystal_ready_o,
  output logic precise_rc_ready_o,
  output logic low_power_rc_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // instruction completion
  logic pending_ff;
  int settle_ff;
  // an instruction only completes on a cpu clock step, so a gated cpu never ends one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
      instr_end_o <= 1'b0;
    end else begin
      instr_end_o <= pending_ff && cpu_clock_enable_i;
      if (step_i) begin
        pending_ff <= 1'b1;
      end else if (cpu_clock_enable_i) begin
        pending_ff <= 1'b0;
      end
    end
  end
  // ==========================================
  // oscillator readiness
  // stopped oscillator loses ready and needs the full settle time again
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_ff <= 0;
    end else if (!oscillator_run_i) begin
      settle_ff <= 0;
    end else if (settle_ff < CRYSTAL_DELAY) begin
      settle_ff <= settle_ff + 1;
    end
  end
  assign crystal_ready_o = (settle_ff >= CRYSTAL_DELAY);
  assign precise_rc_ready_o = (settle_ff >= RC_DELAY);
  assign low_power_rc_ready_o = (settle_ff >= RC_DELAY);
endmodule // cpu_osc_model

// File: clock_prescale_power_modes_test.sv
// self-checking testbench of the clock prescaler and power mode controller
module clock_prescale_power_modes_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rd; logic [1:0] sel;} row_t;
  logic clk, rst, we, instr_end, irq, quiet, ext0_n, ext1_n, en0, en1, step, rdy_a, rdy_b, rdy_c;
  logic [7:0] addr, wdata, rdata, d;
  logic cpu_en, per_en, adc_en, osc_run, hold, strobes;
  logic [1:0] sel;
  int err_count, total_checks, cpu_n, per_n, adc_n, osc_n, g, k;
  row_t rows[12] = '{'{8'h97, 8'hff, 8'h0f, 2'h3}, '{8'h97, 8'h00, 8'h00, 2'h3}, '{8'h8f, 8'hff, 8'h01, 2'h3},
    '{8'h8f, 8'h00, 8'h00, 2'h3}, '{8'h85, 8'h02, 8'h02, 2'h2}, '{8'h85, 8'h00, 8'h02, 2'h2},
    '{8'h85, 8'h01, 8'h01, 2'h1}, '{8'h85, 8'h03, 8'h03, 2'h3}, '{8'h87, 8'h0c, 8'h0c, 2'h3},
    '{8'h87, 8'h00, 8'h00, 2'h3}, '{8'h55, 8'hff, 8'h00, 2'h3}, '{8'h97, 8'h08, 8'h08, 2'h3}};
  logic [3:0] mvals[3] = '{4'hf, 4'h8, 4'h0};
  clock_prescale_power_modes i_clock_prescale_power_modes (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(we), .instr_end_i(instr_end), .irq_pending_i(irq), .quiet_request_i(quiet),
    .external_irq_zero_n_i(ext0_n), .external_irq_one_n_i(ext1_n), .irq_zero_enable_i(en0),
    .irq_one_enable_i(en1), .crystal_ready_i(rdy_a), .precise_rc_ready_i(rdy_b), .low_power_rc_ready_i(rdy_c),
    .reg_rdata_o(rdata), .cpu_clock_enable_o(cpu_en), .periph_clock_enable_o(per_en),
    .adc_clock_enable_o(adc_en), .oscillator_run_o(osc_run), .selected_osc_o(sel), .port_hold_o(hold),
    .strobes_high_o(strobes));
  cpu_osc_model i_cpu_osc_model (.clk_i(clk), .rst_i(rst), .step_i(step), .cpu_clock_enable_i(cpu_en),
    .oscillator_run_i(osc_run), .instr_end_o(instr_end), .crystal_ready_o(rdy_a),
    .precise_rc_ready_o(rdy_b), .low_power_rc_ready_o(rdy_c));
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    // sampled mid-cycle where the registered data has settled
    @(negedge clk);
    d = rdata;
  endtask
  // instruction ends on a later cpu step, so leave room for the slowest divider
  task automatic instr;
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic watch(input int n);
    cpu_n = 0; per_n = 0; adc_n = 0; osc_n = 0;
    repeat (n) begin
      @(negedge clk);
      cpu_n += (cpu_en === 1'b1); per_n += (per_en === 1'b1);
      adc_n += (adc_en === 1'b1); osc_n += (osc_run === 1'b1);
    end
  endtask
  task automatic gap;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      if (cpu_en === 1'b1) break;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (cpu_en !== 1'b1 && g < 100);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  // ==========================================
  // scenarios
  initial begin
    {rst, we, irq, quiet, step, en0, en1} = 7'h42;
    {ext0_n, ext1_n} = 2'h3;
    addr = 8'h00; wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      chk("register", rows[i].rd, d);
      for (k = 0; k < 60 && sel !== rows[i].sel; k++) @(negedge clk);
      chk("source", {6'h00, rows[i].sel}, {6'h00, sel});
    end
    foreach (mvals[i]) begin
      wr(8'h97, {4'h0, mvals[i]});
      gap(); // reload applies at a period boundary, so skip the first period
      gap();
      chk("divider", 8'(16 - mvals[i]), 8'(g));
    end
    wr(8'h8f, 8'h01);
    gap(); gap();
    chk("double speed", 8'h01, 8'(g));
    wr(8'h8f, 8'h00);
    wr(8'h97, 8'h08);
    wr(8'h87, 8'h01);
    instr();
    watch(40);
    chk("idle cpu", 8'h00, 8'(cpu_n));
    chk("idle periph", 8'h01, 8'(per_n > 0));
    chk("idle strobes", 8'h01, {7'h00, strobes});
    chk("idle hold", 8'h01, {7'h00, hold});
    rd(8'h87);
    chk("idle bit", 8'h01, d);
    @(posedge clk) irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    watch(40);
    chk("resume cpu", 8'h01, 8'(cpu_n > 0));
    chk("resume strobes", 8'h00, {7'h00, strobes});
    rd(8'h87);
    chk("idle cleared", 8'h00, d);
    chk("source kept", 8'h03, {6'h00, sel});
    @(posedge clk) quiet <= 1'b1;
    instr();
    quiet <= 1'b0;
    watch(40);
    chk("quiet cpu periph", 8'h00, 8'(cpu_n + per_n));
    chk("quiet adc", 8'h01, 8'(adc_n > 0));
    @(posedge clk) irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    watch(40);
    chk("quiet exit", 8'h01, 8'(cpu_n > 0));
    wr(8'h87, 8'h0e);
    instr();
    watch(40);
    chk("pd stopped", 8'h00, 8'(osc_n + cpu_n + adc_n));
    chk("pd hold", 8'h01, {7'h00, hold});
    @(posedge clk) ext1_n <= 1'b0; // disabled line must not wake
    watch(10);
    @(posedge clk) ext1_n <= 1'b1;
    chk("disabled wake", 8'h00, 8'(osc_n));
    ext0_n <= 1'b0; // held until the oscillator settles
    watch(30);
    chk("wake osc", 8'h01, 8'(osc_n > 0));
    chk("wake cpu held", 8'h00, 8'(cpu_n));
    @(posedge clk) ext0_n <= 1'b1;
    watch(40);
    chk("wake done", 8'h01, 8'(cpu_n > 0));
    rd(8'h87);
    chk("pd flags", 8'h0c, d);
    rd(8'h97);
    chk("pd reload", 8'h08, d);
    @(posedge clk) en1 <= 1'b1;
    wr(8'h87, 8'h03);
    instr();
    watch(30);
    chk("pd wins", 8'h00, {7'h00, strobes} + 8'(osc_n));
    @(posedge clk) {ext0_n, ext1_n} <= 2'h0; // both held past the settle time
    repeat (30) @(posedge clk);
    ext1_n <= 1'b1;
    watch(40);
    chk("first release", 8'h01, 8'(cpu_n > 0));
    @(posedge clk) ext0_n <= 1'b1;
    rd(8'h87);
    chk("both cleared", 8'h00, d);
    wr(8'h97, 8'h03);
    wr(8'h8f, 8'h01);
    wr(8'h87, 8'h01);
    instr();
    watch(1);
    chk("idle again", 8'h01, {7'h00, strobes});
    @(posedge clk) rst <= 1'b1;
    repeat (24) @(posedge clk);
    chk("reset strobes", 8'h00, {7'h00, strobes});
    chk("reset osc", 8'h01, {7'h00, osc_run});
    rst <= 1'b0;
    rd(8'h87);
    chk("reset power", 8'h00, d);
    rd(8'h97);
    chk("reset reload", 8'h08, d);
    rd(8'h8f);
    chk("reset speed", 8'h00, d);
    rd(8'h85);
    chk("reset source", 8'h03, d);
    report_and_stop();
  end
endmodule // clock_prescale_power_modes_test
